// ==== include/exc_src_pkg.sv ====
package exc_src_pkg;

  // vector and class codes
  localparam int VEC_W = 8;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_BOUND = 8'h05;
  localparam logic [7:0] VEC_MACHINE_CHECK = 8'h12;
  localparam logic [7:0] VEC_LOCAL_MIN = 8'h10;
  localparam logic [7:0] VEC_ARCH_MAX = 8'h1f;
  localparam int ERR_W = 16;
  localparam int IP_W = 32;

  typedef enum logic [1:0] {
    CLS_FAULT,
    CLS_TRAP,
    CLS_ABORT,
    CLS_MASKABLE_IRQ_PIN
  } exc_class_e;

endpackage : exc_src_pkg

// ==== rtl/vec_fetch.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// vector fetch for the maskable pin
// ****************************************************
module vec_fetch
  import exc_src_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic bus_vec_valid,
  input wire logic [exc_src_pkg::VEC_W-1:0] bus_vec,
  output logic busy,
  output logic ack_req,
  output logic done,
  output logic [exc_src_pkg::VEC_W-1:0] vec
);

  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_DONE} fetch_e;
  fetch_e st_q;
  fetch_e st_d;

  // next state of the fetch
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      F_IDLE: if (start) st_d = F_WAIT;
      F_WAIT: if (bus_vec_valid) st_d = F_DONE;
      F_DONE: st_d = F_IDLE;
    endcase
  end

  // state and captured vector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= F_IDLE;
      vec <= 8'h00;
    end else begin
      st_q <= st_d;
      if (st_q == F_WAIT && bus_vec_valid) vec <= bus_vec;
    end
  end

  assign busy = (st_q != F_IDLE);
  assign ack_req = (st_q == F_WAIT);
  assign done = (st_q == F_DONE);

endmodule : vec_fetch
`default_nettype wire

// ==== rtl/exc_sourcing.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE_01: maskable pin accepts vectors 0 to 255
// RULE_02: local controller accepts vectors 16-255 only
// RULE_03: local vectors 0-15 flag illegal vector
// RULE_04: interrupt enable flag masks all maskable
// RULE_05: software interrupt dispatches any operand vector
// RULE_06: software vector 2 skips nonmaskable hardware
// RULE_07: software interrupts ignore interrupt enable flag
// RULE_08: software exception vectors push no error code
// RULE_09: breakpoint, overflow, bound raise in-stream exceptions
// RULE_10: machine check raises vector 18 with code
// RULE_11: faults roll state back before instruction
// RULE_12: fault return pointer is faulting instruction
// RULE_13: trap return pointer is next instruction
// RULE_14: aborts report imprecisely, not restartable
// RULE_15: pop-all overrun fault restores pointer only
// RULE_16: dedicated maskable and nonmaskable pins provided
// RULE_17: reset, flush, stop pins bypass this unit
// RULE_18: nonmaskable pin dispatches through vector 2
// RULE_19: maskable pin fetches vector from bus
// RULE_20: events go out with vector, class, code flag
module exc_sourcing
  import exc_src_pkg::*;
#(
  parameter int VW = exc_src_pkg::VEC_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  // external pins
  input wire logic maskable_irq_pin,
  input wire logic nmi_pin,
  input wire logic bus_vec_valid,
  input wire logic [exc_src_pkg::VEC_W-1:0] bus_vec,
  // local controller delivery
  input wire logic local_irq_valid,
  input wire logic [exc_src_pkg::VEC_W-1:0] local_irq_vec,
  // flags and instruction events
  input wire logic irq_enable_flag,
  input wire logic swint_valid,
  input wire logic [exc_src_pkg::VEC_W-1:0] swint_vec,
  input wire logic overflow_check,
  input wire logic bound_check,
  input wire logic mc_error,
  input wire logic [exc_src_pkg::ERR_W-1:0] mc_code,
  input wire logic fault_valid,
  input wire logic [exc_src_pkg::VEC_W-1:0] fault_vec,
  input wire logic fault_has_code,
  input wire logic [exc_src_pkg::ERR_W-1:0] fault_code,
  input wire logic pop_all_overrun,
  input wire logic [exc_src_pkg::IP_W-1:0] insn_ip,
  input wire logic [exc_src_pkg::IP_W-1:0] next_ip,
  input wire logic seq_ready,
  // outputs to the sequencer
  output logic bus_vec_ack,
  output logic illegal_vec,
  output logic evt_valid,
  output logic [exc_src_pkg::VEC_W-1:0] evt_vec,
  output exc_src_pkg::exc_class_e evt_class,
  output logic evt_has_code,
  output logic [exc_src_pkg::ERR_W-1:0] evt_code,
  output logic [exc_src_pkg::IP_W-1:0] evt_ret_ip,
  output logic evt_rollback,
  output logic evt_gpr_dirty,
  output logic evt_nmi_hw
);
  import exc_src_pkg::*;

  initial begin
    if (VW != VEC_W) $error("vector width must be 8");
  end

  // ****************************************************
  // source qualification
  // ****************************************************

  // legal range for local delivery
  function automatic logic local_ok(input logic [7:0] v);
    local_ok = (v >= VEC_LOCAL_MIN);
  endfunction

  logic nmi_q;
  logic mask_pend_q;
  logic nmi_pend_q;
  logic fetch_busy;
  logic fetch_ack;
  logic fetch_done;
  logic [VEC_W-1:0] fetch_vec;
  wire nmi_rise = nmi_pin && !nmi_q; // RULE_18
  wire mask_go = maskable_irq_pin && irq_enable_flag && !fetch_busy; // RULE_04
  wire local_legal = local_irq_valid && local_ok(local_irq_vec); // RULE_02
  wire local_bad = local_irq_valid && !local_ok(local_irq_vec); // RULE_03
  wire local_go = local_legal && irq_enable_flag; // RULE_04
  wire out_free = !evt_valid || seq_ready;

  // maskable pin vector fetch from the bus
  vec_fetch u_fetch (
    .clk(clk),
    .rst_n(rst_n),
    .start(mask_go && !mask_pend_q), // RULE_19
    .bus_vec_valid(bus_vec_valid),
    .bus_vec(bus_vec),
    .busy(fetch_busy),
    .ack_req(fetch_ack),
    .done(fetch_done),
    .vec(fetch_vec)
  );

  // ****************************************************
  // priority selection of one event
  // ****************************************************

  logic sel_any;
  logic [VEC_W-1:0] sel_vec;
  exc_class_e sel_class;
  logic sel_code_en;
  logic [ERR_W-1:0] sel_code;
  logic [IP_W-1:0] sel_ip;
  logic sel_rb;
  logic sel_dirty;
  logic sel_nmi;
  logic take_mask;
  logic take_nmi;

  // machine check, faults, traps, then interrupts
  always_comb begin
    sel_any = 1'b1;
    sel_vec = 8'h00;
    sel_class = CLS_MASKABLE_IRQ_PIN;
    sel_code_en = 1'b0;
    sel_code = 16'h0000;
    sel_ip = next_ip;
    sel_rb = 1'b0;
    sel_dirty = 1'b0;
    sel_nmi = 1'b0;
    take_mask = 1'b0;
    take_nmi = 1'b0;
    if (mc_error) begin
      sel_vec = VEC_MACHINE_CHECK; // RULE_10
      sel_class = CLS_ABORT; // RULE_14
      sel_code_en = 1'b1; // RULE_10
      sel_code = mc_code;
      sel_ip = insn_ip; // RULE_14
    end else if (fault_valid) begin
      sel_vec = fault_vec;
      sel_class = CLS_FAULT;
      sel_code_en = fault_has_code;
      sel_code = fault_code;
      sel_ip = insn_ip; // RULE_12
      sel_rb = !pop_all_overrun; // RULE_11
      sel_dirty = pop_all_overrun; // RULE_15
    end else if (bound_check) begin
      sel_vec = VEC_BOUND; // RULE_09
      sel_class = CLS_FAULT;
      sel_ip = insn_ip; // RULE_12
      sel_rb = 1'b1; // RULE_11
    end else if (overflow_check) begin
      sel_vec = VEC_OVERFLOW; // RULE_09
      sel_class = CLS_TRAP;
      sel_ip = next_ip; // RULE_13
    end else if (swint_valid) begin
      sel_vec = swint_vec; // RULE_05
      sel_class = (swint_vec == VEC_BREAKPOINT) ? CLS_TRAP : CLS_MASKABLE_IRQ_PIN;
      sel_code_en = 1'b0; // RULE_08
      sel_ip = next_ip; // RULE_13
      sel_nmi = 1'b0; // RULE_06
    end else if (nmi_pend_q) begin
      sel_vec = VEC_NMI; // RULE_18
      sel_nmi = 1'b1;
      take_nmi = 1'b1;
    end else if (mask_pend_q) begin
      sel_vec = fetch_vec; // RULE_01
      take_mask = 1'b1;
    end else if (local_go) begin
      sel_vec = local_irq_vec; // RULE_02
    end else begin
      sel_any = 1'b0;
    end
  end

  // ****************************************************
  // pending flags and output register
  // ****************************************************

  // pending interrupts, set wins over take
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      mask_pend_q <= 1'b0;
    end else begin
      nmi_q <= nmi_pin;
      if (nmi_rise) nmi_pend_q <= 1'b1;
      else if (take_nmi && out_free) nmi_pend_q <= 1'b0;
      if (fetch_done) mask_pend_q <= 1'b1; // RULE_19
      else if (take_mask && out_free) mask_pend_q <= 1'b0;
    end
  end

  // event handed to the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_valid <= 1'b0;
      evt_vec <= 8'h00;
      evt_class <= CLS_MASKABLE_IRQ_PIN;
      evt_has_code <= 1'b0;
      evt_code <= 16'h0000;
      evt_ret_ip <= 32'h00000000;
      evt_rollback <= 1'b0;
      evt_gpr_dirty <= 1'b0;
      evt_nmi_hw <= 1'b0;
    end else if (out_free) begin
      evt_valid <= sel_any; // RULE_20
      evt_vec <= sel_vec;
      evt_class <= sel_class;
      evt_has_code <= sel_code_en;
      evt_code <= sel_code_en ? sel_code : 16'h0000;
      evt_ret_ip <= sel_ip;
      evt_rollback <= sel_rb;
      evt_gpr_dirty <= sel_dirty;
      evt_nmi_hw <= sel_nmi;
    end
  end

  // registered side outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_vec_ack <= 1'b0;
      illegal_vec <= 1'b0;
    end else begin
      bus_vec_ack <= fetch_ack && bus_vec_valid;
      illegal_vec <= local_bad; // RULE_03
    end
  end

  // reset, flush, clock stop, sys mgmt pins never reach here  RULE_17
  // dedicated pin pair used when no local controller  RULE_16

endmodule : exc_sourcing
`default_nettype wire

// ==== bench/ext_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// external controller model
// ****
module ext_ctl_model (
  input wire logic clk,
  input wire logic mreq,
  input wire logic [7:0] mvec,
  input wire logic bus_vec_ack,
  output logic maskable_irq_pin,
  output logic bus_vec_valid,
  output logic [7:0] bus_vec
);
  logic go;
  // pin up, vector after a random wait, hold until taken
  initial begin
    {maskable_irq_pin, bus_vec_valid, bus_vec} = '0;
    forever begin
      @(posedge clk);
      go = mreq;
      #1;
      if (!go)
        bus_vec = ~bus_vec; // idle bus shows junk
      else begin
        maskable_irq_pin = 1;
        repeat ($urandom % 4 + 1) @(posedge clk);
        #1 bus_vec_valid = 1;
        bus_vec = mvec;
        while (bus_vec_ack !== 1'b1) begin
          @(posedge clk);
          #1;
        end
        @(posedge clk);
        #1 {maskable_irq_pin, bus_vec_valid} = '0;
        bus_vec = ~mvec;
      end
    end
  end
endmodule : ext_ctl_model
`default_nettype wire

// ==== bench/exc_sourcing_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module exc_sourcing_assertions
  import exc_src_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_vec_valid,
  input wire logic local_irq_valid,
  input wire logic [7:0] local_irq_vec,
  input wire logic swint_valid,
  input wire logic [7:0] swint_vec,
  input wire logic overflow_check,
  input wire logic bound_check,
  input wire logic mc_error,
  input wire logic fault_valid,
  input wire logic [31:0] insn_ip,
  input wire logic [31:0] next_ip,
  input wire logic seq_ready,
  input wire logic bus_vec_ack,
  input wire logic illegal_vec,
  input wire logic evt_valid,
  input wire logic [7:0] evt_vec,
  input wire exc_class_e evt_class,
  input wire logic evt_has_code,
  input wire logic [31:0] evt_ret_ip,
  input wire logic evt_nmi_hw
);
  // output free, higher sources
  wire free = !evt_valid || seq_ready;
  wire hi = mc_error || fault_valid || bound_check || overflow_check;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_swint_vec: assert property (
    swint_valid && !hi && free |=> evt_valid && evt_vec == $past(swint_vec))
    else $error("swint vector wrong");
  a_mc_abort: assert property (
    mc_error && free |=> evt_vec == VEC_MACHINE_CHECK && evt_has_code
    && evt_class == CLS_ABORT) else $error("machine check wrong");
  a_fault_ret: assert property (
    fault_valid && !mc_error && free |=> evt_class == CLS_FAULT
    && evt_ret_ip == $past(insn_ip)) else $error("fault pointer wrong");
  a_trap_ret: assert property (
    overflow_check && !mc_error && !fault_valid && !bound_check && free
    |=> evt_vec == VEC_OVERFLOW && evt_ret_ip == $past(next_ip))
    else $error("trap pointer wrong");
  a_illegal_src: assert property (
    illegal_vec |-> $past(local_irq_valid && local_irq_vec < VEC_LOCAL_MIN))
    else $error("illegal flag without cause");
  a_nmi_vec: assert property (
    evt_nmi_hw |-> evt_vec == VEC_NMI && evt_class == CLS_MASKABLE_IRQ_PIN)
    else $error("nmi vector wrong");
  a_hold_stall: assert property (
    evt_valid && !seq_ready |=> evt_valid && $stable(evt_vec)
    && $stable(evt_ret_ip)) else $error("event dropped in stall");
  a_ack_bus: assert property (
    bus_vec_ack |-> $past(bus_vec_valid)) else $error("ack without vector");
  c_mc: cover property (mc_error && free);
  c_stall: cover property (evt_valid && !seq_ready);
  c_ack: cover property (bus_vec_ack);
endmodule : exc_sourcing_assertions
bind exc_sourcing exc_sourcing_assertions exc_sourcing_assertions_i (.*);
`default_nettype wire

// ==== bench/interrupt_exception_sourcing_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// sourcing unit bench
// ****
module interrupt_exception_sourcing_test;
  import exc_src_pkg::*;
  logic clk = 0, rst_n = 0, mreq = 0, seq_ready = 1;
  logic maskable_irq_pin, bus_vec_valid, bus_vec_ack, illegal_vec, evt_valid;
  logic nmi_pin, local_irq_valid, irq_enable_flag, swint_valid, bound_check;
  logic overflow_check, mc_error, fault_valid, fault_has_code;
  logic pop_all_overrun, evt_has_code, evt_rollback, evt_gpr_dirty, evt_nmi_hw;
  logic [7:0] bus_vec, local_irq_vec, swint_vec, fault_vec, evt_vec, mvec;
  logic [15:0] mc_code, fault_code, evt_code;
  logic [31:0] insn_ip, next_ip, evt_ret_ip;
  logic [7:0] b[6] = '{8'h00, 8'h02, 8'h03, 8'h0f, 8'h10, 8'hff};
  exc_class_e evt_class;
  int err_total = 0, tests_run = 0, cyc = 0, n, q[$];
  exc_sourcing exc_sourcing_i (.*);
  ext_ctl_model ext_ctl_model_i (.*);
  always #50 clk = ~clk;
  // hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // k: swint ovf bound mc fault nmi local
  task automatic go(input int k, input logic [7:0] v, input logic en);
    int ec;
    logic ok;
    irq_enable_flag = en;
    {insn_ip, next_ip} = {$urandom, $urandom};
    {mc_code, fault_code} = $urandom;
    {fault_has_code, pop_all_overrun} = 2'($urandom);
    {swint_vec, local_irq_vec, fault_vec} = {v, v, v};
    {swint_valid, overflow_check, bound_check, mc_error, fault_valid,
      nmi_pin, local_irq_valid} = 7'h40 >> k;
    @(posedge clk);
    #1 {swint_valid, overflow_check, bound_check, mc_error} = '0;
    {fault_valid, nmi_pin, local_irq_valid} = '0;
    // nmi edge is latched first, so its event comes one cycle later
    if (k == 5) begin
      @(posedge clk);
      #1;
    end
    ec = k == 1 || (k == 0 && v == 3) ? 1 : k == 3 ? 2 : k == 2 || k == 4 ? 0 : 3;
    ok = k < 7 && !(k == 6 && (v < 16 || !en));
    chk(ok, evt_valid);
    chk(k == 6 && v < 16, illegal_vec);
    if (ok) begin
      q.push_back(k == 1 ? 4 : k == 2 ? 5 : k == 3 ? 18 : k == 5 ? 2 : v);
      chk(q.pop_front(), evt_vec);
      chk(ec, evt_class);
      chk(k == 3 || k == 4 && fault_has_code, evt_has_code);
      if (k == 3 || k == 4 && fault_has_code)
        chk(k == 3 ? mc_code : fault_code, evt_code);
      chk(ec == 0 || k == 3 ? insn_ip : next_ip, evt_ret_ip);
      chk(k == 4 && pop_all_overrun, evt_gpr_dirty);
      chk(ec == 0 && !(k == 4 && pop_all_overrun), evt_rollback);
      chk(k == 5, evt_nmi_hw);
    end
    @(posedge clk);
    #1;
  endtask : go
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    void'($urandom(32'h085a4339));
    go(7, 0, 0);
    rst_n = 0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 70; i++) go(i % 7, 8'($urandom), 1'($urandom));
    foreach (b[j]) begin
      go(0, b[j], 0);
      go(6, b[j], 1);
    end
    $display("sources done");
    seq_ready = 0;
    {swint_valid, swint_vec} = 9'h155;
    @(posedge clk);
    #1 swint_valid = 0;
    repeat (3) @(posedge clk);
    #1 chk(8'h55, evt_vec);
    {seq_ready, rst_n} = 2'b10;
    #1 chk(0, evt_valid);
    @(posedge clk);
    #1 rst_n = 1;
    $display("stall and reset done");
    repeat (4) begin
      {irq_enable_flag, mreq, mvec} = {2'b11, 8'($urandom)};
      @(posedge clk);
      #1 mreq = 0;
      for (n = 0; evt_valid !== 1'b1 && n < 50; n++) begin
        @(posedge clk);
        #1;
      end
      chk(mvec, evt_vec);
      repeat (6) @(posedge clk);
      #1;
    end
    $display("maskable pin done");
    wrap_up();
  end
endmodule : interrupt_exception_sourcing_test
`default_nettype wire
